// *** verilog/cce_exec.sv ***
// execution of the complement and compare-skip-equal byte instructions, with an axi4-lite control slave
// Operation
// RULE_01: complement op inverts addressed register, delivers it, updates only negative and zero
// RULE_02: destination bit zero writes accumulator; one writes back to the source register
// RULE_03: access bit zero uses access bank; one uses bank select pointer
// RULE_04: extended set, access bit zero, address at most 95: indexed literal offset addressing
// RULE_05: compare op subtracts unsigned, stores nothing, leaves all flags unchanged
// RULE_06: on equality the fetched next instruction is replaced by a no-operation cycle
// RULE_07: skipping a two-word instruction costs three cycles, both words flushed
// RULE_08: complement is one word, one cycle: decode, read, process, write phases
`timescale 1ns/1ps
`include "cce_defs.svh"
module cce_exec (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic next_two_word,
	output logic instr_ready,
	output logic nop_active,
	output cce_pkg::mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cce_pkg::*;

	logic [1:0] q_reg;
	exec_state_t state_reg;
	op_kind_t op_reg;
	logic dest_reg;
	logic [7:0] data_reg;
	logic equal_reg;
	logic [1:0] flush_reg;
	logic ext_en_reg;
	logic [3:0] bank_select_pointer_reg;
	logic [7:0] acc_reg;
	logic [1:0] flags_reg;
	logic [11:0] index_reg;
	logic [11:0] addr_next;
	op_kind_t op_next;
	logic take;
	logic skip_now;
	logic aw_held, w_held;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write, aw_take, w_take, ar_take;
	logic aw_held_next, w_held_next, bvalid_next, rvalid_next;
	logic sw_wr_ctrl, sw_wr_bank, sw_wr_acc, sw_wr_flags, sw_wr_index;

	// a new instruction is taken only in the decode phase and never while flushing
	assign take = instr_ready && instr_valid;
	assign skip_now = (state_reg == st_exec) && (op_reg == op_cpseq) && (q_reg == `CCE_Q_LAST) && equal_reg;

	// opcode decode of the incoming word
	always_comb begin
		op_next = op_none;
		if (instr[15:10] == `CCE_CPL_OPC) begin
			op_next = op_cpl; // see RULE_01
		end else if (instr[15:9] == `CCE_CPSEQ_OPC) begin
			op_next = op_cpseq; // see RULE_05
		end
	end

	// effective data address from access bit, bank pointer and extended mode
	always_comb begin
		if (instr[8]) begin
			addr_next = {bank_select_pointer_reg, instr[7:0]}; // see RULE_03
		end else if (ext_en_reg && instr[7:0] <= `CCE_ILO_LIMIT) begin
			addr_next = index_reg + {4'h0, instr[7:0]}; // see RULE_04
		end else if (instr[7:0] <= `CCE_ILO_LIMIT) begin
			addr_next = {4'h0, instr[7:0]}; // see RULE_03
		end else begin
			addr_next = {`CCE_ACC_HIGH_BASE, instr[7:0]};
		end
	end

	// four-phase counter that paces every instruction cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_reg <= 2'h0;
		end else begin
			q_reg <= q_reg + 2'h1;
		end
	end

	// sequencing: decode, flush of skipped words and the ready handshake
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= st_idle;
			op_reg <= op_none;
			dest_reg <= 1'b0;
			flush_reg <= 2'h0;
			instr_ready <= 1'b0;
			nop_active <= 1'b0;
		end else begin
			if (take) begin
				state_reg <= st_exec;
				op_reg <= op_next;
				dest_reg <= instr[9];
			end else if (q_reg == `CCE_Q_LAST) begin
				if (skip_now) begin
					state_reg <= st_flush; // see RULE_06
					flush_reg <= next_two_word ? `CCE_FLUSH_TWO : `CCE_FLUSH_ONE; // see RULE_07
				end else if (flush_reg > `CCE_FLUSH_ONE) begin
					flush_reg <= flush_reg - 2'h1; // see RULE_07
				end else begin
					flush_reg <= 2'h0;
					state_reg <= st_idle;
				end
			end
			instr_ready <= (q_reg == `CCE_Q_LAST) && !skip_now && (flush_reg <= `CCE_FLUSH_ONE);
			if (q_reg == `CCE_Q_LAST) begin
				nop_active <= skip_now || (flush_reg > `CCE_FLUSH_ONE); // see RULE_06
			end
		end
	end

	// data memory: read in phase two, write-back in phase four
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_req <= '0;
		end else begin
			mem_req.rd <= take && (op_next != op_none); // see RULE_08
			mem_req.wr <= (state_reg == st_exec) && (q_reg == 2'h2) && (op_reg == op_cpl) && dest_reg; // see RULE_02
			if (take) begin
				mem_req.addr <= addr_next;
			end
			if (q_reg == 2'h2) begin
				mem_req.wdata <= ~data_reg; // see RULE_01
			end
		end
	end

	// operand capture and compare processing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_reg <= 8'h00;
			equal_reg <= 1'b0;
		end else begin
			if (mem_req.rd) begin
				data_reg <= mem_rdata;
			end
			if (q_reg == 2'h2) begin
				equal_reg <= (data_reg - acc_reg) == 8'h00; // see RULE_05
			end
		end
	end

	// accumulator, flags and software-owned control; hardware update wins over a bus write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_reg <= `CCE_ACC_RST;
			flags_reg <= `CCE_FLAGS_RST;
			ext_en_reg <= `CCE_CTRL_RST;
			bank_select_pointer_reg <= `CCE_BANK_RST;
			index_reg <= `CCE_INDEX_RST;
		end else begin
			if ((state_reg == st_exec) && (q_reg == `CCE_Q_LAST) && (op_reg == op_cpl)) begin
				if (!dest_reg) begin
					acc_reg <= mem_req.wdata; // see RULE_02
				end
				flags_reg[`CCE_FLAG_N_BIT] <= mem_req.wdata[7]; // see RULE_01
				flags_reg[`CCE_FLAG_Z_BIT] <= mem_req.wdata == 8'h00; // see RULE_01
			end else begin
				if (sw_wr_acc) begin
					acc_reg <= wdata_q[7:0];
				end
				if (sw_wr_flags) begin
					flags_reg <= wdata_q[1:0];
				end
			end
			if (sw_wr_ctrl) begin
				ext_en_reg <= wdata_q[`CCE_CTRL_EXT_BIT];
			end
			if (sw_wr_bank) begin
				bank_select_pointer_reg <= wdata_q[3:0];
			end
			if (sw_wr_index && wstrb_q[1]) begin
				index_reg[11:8] <= wdata_q[11:8];
			end
			if (sw_wr_index) begin
				index_reg[7:0] <= wdata_q[7:0];
			end
		end
	end

	// axi4-lite handshake terms
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign aw_held_next = aw_take || (aw_held && !do_write);
	assign w_held_next = w_take || (w_held && !do_write);
	assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
	assign rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);
	assign sw_wr_ctrl = do_write && wstrb_q[0] && (awaddr_q == `CCE_CTRL_OFF);
	assign sw_wr_bank = do_write && wstrb_q[0] && (awaddr_q == `CCE_BANK_OFF);
	assign sw_wr_acc = do_write && wstrb_q[0] && (awaddr_q == `CCE_ACC_OFF);
	assign sw_wr_flags = do_write && wstrb_q[0] && (awaddr_q == `CCE_FLAGS_OFF);
	assign sw_wr_index = do_write && wstrb_q[0] && (awaddr_q == `CCE_INDEX_OFF);

	// write channel: address and data taken in either order, one response after both
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCE_RESP_OKAY;
		end else begin
			aw_held <= aw_held_next;
			w_held <= w_held_next;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			s_axi_awready <= !aw_held_next && !bvalid_next;
			s_axi_wready <= !w_held_next && !bvalid_next;
			s_axi_bvalid <= bvalid_next;
			if (do_write) begin
				s_axi_bresp <= (awaddr_q <= `CCE_INDEX_OFF && awaddr_q[1:0] == 2'h0) ?
					`CCE_RESP_OKAY : `CCE_RESP_SLVERR;
			end
		end
	end

	// read channel: data answered one cycle after the address is taken
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CCE_RESP_OKAY;
		end else begin
			s_axi_arready <= !rvalid_next;
			s_axi_rvalid <= rvalid_next;
			if (ar_take) begin
				s_axi_rresp <= `CCE_RESP_OKAY;
				unique case (s_axi_araddr)
					`CCE_CTRL_OFF: s_axi_rdata <= {31'h0, ext_en_reg};
					`CCE_BANK_OFF: s_axi_rdata <= {28'h0, bank_select_pointer_reg};
					`CCE_ACC_OFF: s_axi_rdata <= {24'h0, acc_reg};
					`CCE_FLAGS_OFF: s_axi_rdata <= {30'h0, flags_reg};
					`CCE_INDEX_OFF: s_axi_rdata <= {20'h0, index_reg};
					`CCE_STAT_OFF: s_axi_rdata <= {26'h0, nop_active, state_reg == st_exec, flush_reg, q_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `CCE_RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule

// *** verilog/cce_defs.svh ***
// constants for the complement and compare-skip execution block
`ifndef CCE_DEFS_SVH
`define CCE_DEFS_SVH
// register byte offsets
`define CCE_CTRL_OFF 8'h00
`define CCE_BANK_OFF 8'h04
`define CCE_ACC_OFF 8'h08
`define CCE_FLAGS_OFF 8'h0C
`define CCE_INDEX_OFF 8'h10
`define CCE_STAT_OFF 8'h14
// field positions
`define CCE_CTRL_EXT_BIT 0
`define CCE_FLAG_Z_BIT 0
`define CCE_FLAG_N_BIT 1
// reset values
`define CCE_CTRL_RST 1'h0
`define CCE_BANK_RST 4'h0
`define CCE_ACC_RST 8'h00
`define CCE_FLAGS_RST 2'h0
`define CCE_INDEX_RST 12'h000
// opcode fields
`define CCE_CPL_OPC 6'h07
`define CCE_CPSEQ_OPC 7'h31
// addressing
`define CCE_ILO_LIMIT 8'h5F
`define CCE_ACC_HIGH_BASE 4'hF
// answers
`define CCE_RESP_OKAY 2'h0
`define CCE_RESP_SLVERR 2'h2
// phase and flush counts
`define CCE_Q_LAST 2'h3
`define CCE_FLUSH_ONE 2'h1
`define CCE_FLUSH_TWO 2'h2
`endif

// *** verilog/cce_pkg.sv ***
// types shared by the execution block and its bench
package cce_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
	typedef enum logic [1:0] {op_none, op_cpl, op_cpseq} op_kind_t;
	typedef enum logic [1:0] {st_idle, st_exec, st_flush} exec_state_t;
endpackage

// *** sim/cce_exec_monitor.sv ***
// assertions on the instruction side of the execution block
`timescale 1ns/1ps
module cce_exec_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic next_two_word,
	input wire logic instr_ready,
	input wire logic nop_active,
	input cce_pkg::mem_req_t mem_req,
	input wire logic [7:0] mem_rdata
);
	import cce_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// accepted instructions of each kind
	sequence take_s;
		instr_ready && instr_valid;
	endsequence
	sequence cpl_wb_s;
		take_s ##0 (instr[15:9] == 7'h0F);
	endsequence
	sequence cmp_s;
		take_s ##0 (instr[15:9] == 7'h31);
	endsequence
	// unknown opcodes are taken but touch no memory, so only decoded ones must read
	sequence known_s;
		take_s ##0 ((instr[15:10] == 6'h07) || (instr[15:9] == 7'h31));
	endsequence
	a_take_read: assert property (known_s |=> mem_req.rd ##1 !mem_req.rd) else $error("no read pulse");
	a_ready_once: assert property (instr_ready |=> !instr_ready [*3]) else $error("ready too often");
	a_cpl_wb: assert property (cpl_wb_s |-> ##3 mem_req.wr) else $error("no write back");
	a_cpl_data: assert property (cpl_wb_s ##3 1'b1 |-> mem_req.wdata == ~$past(mem_rdata, 2))
		else $error("bad complement");
	a_cmp_nostore: assert property (cmp_s |-> ##1 !mem_req.wr [*3]) else $error("compare stored");
	a_skip_len: assert property ($rose(nop_active) |-> nop_active [*4]) else $error("short flush");
	a_nop_quiet: assert property (nop_active |-> !instr_ready && !mem_req.rd && !mem_req.wr)
		else $error("flush not idle");
	a_skip_two: assert property (cmp_s ##3 next_two_word ##1 nop_active |-> nop_active [*8])
		else $error("two word flush short");
endmodule

// *** sim/test_complement_and_compare_skip_exec.sv ***
// bench for the complement and compare-skip execution block
`timescale 1ns/1ps
`include "cce_defs.svh"
module test_complement_and_compare_skip_exec;
	import cce_pkg::*;
	logic clk = 0, reset = 1, instr_valid = 0, next_two_word = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [15:0] instr = 16'h0000;
	logic [7:0] awa = 8'h00, ara = 8'h00, mem_rdata;
	logic [31:0] wd = 32'h00000000, rdata, rdv;
	logic instr_ready, nop_active, awr, wr_rdy, bv, arr, rv;
	logic [1:0] bresp, rresp, rrs, brs;
	logic [11:0] ra;
	logic [7:0] mem [0:4095];
	mem_req_t mq;
	int mismatches = 0, compares = 0;
	cce_exec cce_exec_inst (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
		.next_two_word(next_two_word), .instr_ready(instr_ready), .nop_active(nop_active), .mem_req(mq),
		.mem_rdata(mem_rdata), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
	// data memory answers at once and records the last read address
	assign mem_rdata = mem[mq.addr];
	always @(posedge clk) begin
		if (mq.wr) mem[mq.addr] <= mq.wdata;
		if (mq.rd) ra <= mq.addr;
	end
	always #12.5 clk = ~clk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// a used-up wait counts against the run
	task to(input int n);
		if (n >= 60) begin
			mismatches++;
			end_of_test;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 0;
			if (wr_rdy) wv <= 0;
		end while (bv !== 1 && n < 60);
		brs = bresp;
		br <= 0;
		to(n);
	endtask
	task rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rr <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arr) arv <= 0;
		end while (rv !== 1 && n < 60);
		rdv = rdata;
		rrs = rresp;
		rr <= 0;
		to(n);
	endtask
	// offer one word, then count clocks until the next take slot
	task ex(input logic [15:0] w, input logic two, input int cyc);
		int n;
		int k;
		instr <= w;
		instr_valid <= 1;
		next_two_word <= two;
		n = 0;
		do begin @(posedge clk); n++; end while (instr_ready !== 1 && n < 60);
		instr_valid <= 0;
		to(n);
		n = 0;
		k = 0;
		do begin
			@(posedge clk);
			n++;
			if (nop_active === 1) k++;
		end while (instr_ready !== 1 && n < 60);
		chk("cycles", n, cyc);
		chk("nops", k, cyc - 4);
	endtask
	task t_bus;
		rd(`CCE_CTRL_OFF);
		chk("ctrl", rdv, 32'h0);
		chk("rresp", rrs, `CCE_RESP_OKAY);
		rd(8'h40);
		chk("unmapped", rdv, 32'h0);
		chk("unmapped rresp", rrs, `CCE_RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk("unmapped bresp", brs, `CCE_RESP_SLVERR);
		$display("bus test done");
	endtask
	task t_complement_register_op;
		wr(`CCE_BANK_OFF, 32'h3);
		chk("bresp", brs, `CCE_RESP_OKAY);
		mem[12'h3A5] = 8'h13;
		mem[12'hF60] = 8'hFF;
		ex(16'h1FA5, 0, 4);
		chk("wb", mem[12'h3A5], 8'hEC);
		chk("bank", ra, 12'h3A5);
		rd(`CCE_FLAGS_OFF);
		chk("n", rdv, 32'h2);
		wr(`CCE_ACC_OFF, 32'h77);
		ex(16'h1C60, 0, 4);
		chk("src", mem[12'hF60], 8'hFF);
		rd(`CCE_ACC_OFF);
		chk("acc", rdv, 32'h0);
		rd(`CCE_FLAGS_OFF);
		chk("z", rdv, 32'h1);
		$display("complement test done");
	endtask
	task t_cmp;
		wr(`CCE_ACC_OFF, 32'h5A);
		wr(`CCE_FLAGS_OFF, 32'h3);
		mem[12'h010] = 8'h5A;
		mem[12'h011] = 8'h5B;
		mem[12'h310] = 8'h5A;
		mem[12'h25F] = 8'h5A;
		ex(16'h6210, 0, 8);
		chk("access", ra, 12'h010);
		ex(16'h6210, 1, 12);
		ex(16'h6211, 1, 4);
		ex(16'h6310, 0, 8);
		chk("bank", ra, 12'h310);
		wr(`CCE_CTRL_OFF, 32'h1);
		wr(`CCE_INDEX_OFF, 32'h200);
		ex(16'h625F, 0, 8);
		chk("ilo", ra, 12'h25F);
		ex(16'h6260, 0, 4);
		chk("top", ra, 12'hF60);
		ex(16'h0000, 0, 4);
		chk("none", ra, 12'hF60);
		chk("keep", mem[12'h010], 8'h5A);
		rd(`CCE_FLAGS_OFF);
		chk("flags", rdv, 32'h3);
		rd(`CCE_ACC_OFF);
		chk("w", rdv, 32'h5A);
		$display("compare test done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		repeat (2) @(posedge clk);
		t_bus;
		t_complement_register_op;
		t_cmp;
		end_of_test;
	end
endmodule
bind cce_exec cce_exec_monitor cce_exec_monitor_inst (.clk(clk), .reset(reset), .instr(instr),
	.instr_valid(instr_valid), .next_two_word(next_two_word), .instr_ready(instr_ready),
	.nop_active(nop_active), .mem_req(mem_req), .mem_rdata(mem_rdata));
